// *** common/sssp_defs.vh ***
// register map, field positions and reset values for the spread and phase step block
`ifndef SSSP_DEFS_VH
`define SSSP_DEFS_VH

`define SSSP_ADDR_W 8

// register byte offsets
`define SSSP_OFS_SPREAD_CTRL 8'h00
`define SSSP_OFS_LOOP_CTRL1 8'h04
`define SSSP_OFS_FB_LO 8'h08
`define SSSP_OFS_FB_HI 8'h0C
`define SSSP_OFS_FR_LO 8'h10
`define SSSP_OFS_FR_HI 8'h14
`define SSSP_OFS_STEP 8'h18
`define SSSP_OFS_RAMP 8'h1C
`define SSSP_OFS_LOOP_CTRL4 8'h20
`define SSSP_OFS_STATUS 8'h24
`define SSSP_OFS_CUR_FB_LO 8'h28
`define SSSP_OFS_CUR_FR_LO 8'h2C

// spread_control_reg fields
`define SSSP_SC_EN 0
`define SSSP_SC_DOWN 1
`define SSSP_SC_PIN_LSB 2
`define SSSP_SC_PIN_MSB 4
`define SSSP_SC_PRE_LSB 5
`define SSSP_SC_PRE_MSB 6

// loop_control_one fields
`define SSSP_LC1_DIVSEL 0

// loop_control_four fields
`define SSSP_LC4_DEC 0
`define SSSP_LC4_INC 1
`define SSSP_LC4_DSRC_LSB 2
`define SSSP_LC4_DSRC_MSB 4
`define SSSP_LC4_ISRC_LSB 5
`define SSSP_LC4_ISRC_MSB 7

// status fields
`define SSSP_ST_LOCK 0
`define SSSP_ST_ACTIVE 1
`define SSSP_ST_DOWN 2
`define SSSP_ST_EIGHTH 3

// trigger source codes: 0 software bit, 1..4 gpio 0..3
`define SSSP_SRC_SW 3'h0
`define SSSP_SRC_GPIO0 3'h1

// feedback divider has 33 fractional bits; half-multiple test looks below bit 32
`define SSSP_FB_HALF_LSB 0
`define SSSP_FB_HALF_MSB 31

// reset values
`define SSSP_RST_FB 42'h000_0000_0000
`define SSSP_RST_FR 40'h00_0000_0000
`define SSSP_RST_RAMP 16'h0000
`define SSSP_RST_STEP 32'h0000_0000

`endif

// *** hdl/sssp_top.v ***
// spread-spectrum triangle modulation and phase step control of the loop dividers
//
// Contract
// [RQ1] spreading enabled by enable bit or by gpio picked by pin select
// [RQ2] divider select 0 modulates feedback divider from its nominal register value
// [RQ3] center spread: step each cycle, ramp of count cycles is quarter period; the code ramps count plus two ticks in both modes
// [RQ4] down spread: triangle below nominal, ramp is half period, count plus two
// [RQ5] feedback center spread supports up to half percent, 25 to 55 kHz
// [RQ6] feedback down spread supports down to minus one percent
// [RQ7] software scales feedback step by 2^32 center, 2^33 down
// [RQ8] software sets feedback remainder 0, denominator 1, binary point 0
// [RQ9] modulation only while loop lock flag is 1
// [RQ10] divider select 1 modulates fractional divider from its nominal value
// [RQ11] fractional center spread supports up to five percent, 10 to 100 kHz
// [RQ12] fractional down spread supports down to minus ten percent
// [RQ13] fractional ramp count prescaled by two to count prescale field
// [RQ14] software scales fractional step by 2^34 center, 2^35 down
// [RQ15] software sets fractional remainder 0, denominator 1, binary point 0
// [RQ16] software sets fractional operating mode to 1 during spreading
// [RQ17] non half-multiple feedback value: phase step is one eighth oscillator cycle
// [RQ18] half-multiple feedback value: phase step is one oscillator cycle
// [RQ19] phase decrement trigger picked from software bit or four gpios
// [RQ20] phase increment trigger picked from software bit or four gpios
// [RQ21] one phase step on every rising and falling trigger edge
// [RQ22] phase steps shift both integer and fractional output dividers
// [RQ23] software never mixes frequency stepping with spreading
// [RQ24] counter reloads count plus two at ramp end, direction follows reloads; the code reloads count plus one, for a ramp of count plus two ticks
// [RQ25] disable or lock loss returns divider to nominal and resets ramp
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`include "sssp_defs.vh"

module sssp_top #(
    parameter FB_W = 42,
    parameter FR_W = 40,
    parameter STEP_W = 32,
    parameter CNT_W = 16,
    parameter GPIO_N = 4
) (
    input wire ref_clk_i,
    input wire rst_i,
    input wire [`SSSP_ADDR_W-1:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    input wire loop_lock_i,
    input wire [GPIO_N-1:0] gpio_i,
    output reg [FB_W-1:0] fb_div_o,
    output reg [FR_W-1:0] frac_div_o,
    output reg spread_active_o,
    output reg phase_inc_int_o,
    output reg phase_dec_int_o,
    output reg phase_inc_frac_o,
    output reg phase_dec_frac_o,
    output reg phase_step_eighth_o
);

    // picks software bit or one gpio; codes past the gpio range read as low
    function src_pick;
        input [2:0] sel;
        input sw_bit;
        input [GPIO_N-1:0] gp;
        integer k;
        begin
            src_pick = 1'b0;
            if (sel == `SSSP_SRC_SW) begin
                src_pick = sw_bit;
            end
            for (k = 0; k < GPIO_N; k = k + 1) begin
                if (sel == `SSSP_SRC_GPIO0 + k[2:0]) begin
                    src_pick = gp[k];
                end
            end
        end
    endfunction

    // one address compare shared by every register strobe
    function reg_hit;
        input [`SSSP_ADDR_W-1:0] addr;
        input [`SSSP_ADDR_W-1:0] ofs;
        begin
            reg_hit = (addr == ofs);
        end
    endfunction

    // register widths follow the top field of each control word
    localparam SC_W = `SSSP_SC_PRE_MSB + 1;
    localparam LC4_W = `SSSP_LC4_ISRC_MSB + 1;

    // control registers
    reg [SC_W-1:0] spread_ctrl_q;
    reg divsel_q;
    reg [FB_W-1:0] fb_nom_q;
    reg [FR_W-1:0] fr_nom_q;
    reg [STEP_W-1:0] step_q;
    reg [CNT_W-1:0] ramp_q;
    reg [LC4_W-1:0] loop_ctrl4_q;

    wire wr_sc = wr_i && reg_hit(addr_i, `SSSP_OFS_SPREAD_CTRL);
    wire wr_lc1 = wr_i && reg_hit(addr_i, `SSSP_OFS_LOOP_CTRL1);
    wire wr_fbl = wr_i && reg_hit(addr_i, `SSSP_OFS_FB_LO);
    wire wr_fbh = wr_i && reg_hit(addr_i, `SSSP_OFS_FB_HI);
    wire wr_frl = wr_i && reg_hit(addr_i, `SSSP_OFS_FR_LO);
    wire wr_frh = wr_i && reg_hit(addr_i, `SSSP_OFS_FR_HI);
    wire wr_stp = wr_i && reg_hit(addr_i, `SSSP_OFS_STEP);
    wire wr_rmp = wr_i && reg_hit(addr_i, `SSSP_OFS_RAMP);
    wire wr_lc4 = wr_i && reg_hit(addr_i, `SSSP_OFS_LOOP_CTRL4);

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            spread_ctrl_q <= {SC_W{1'b0}};
            divsel_q <= 1'b0;
            fb_nom_q <= `SSSP_RST_FB;
            fr_nom_q <= `SSSP_RST_FR;
            step_q <= `SSSP_RST_STEP;
            ramp_q <= `SSSP_RST_RAMP;
            loop_ctrl4_q <= {LC4_W{1'b0}};
        end else begin
            if (wr_sc) begin
                spread_ctrl_q <= wdata_i[SC_W-1:0];
            end
            if (wr_lc1) begin
                divsel_q <= wdata_i[`SSSP_LC1_DIVSEL];
            end
            if (wr_fbl) begin
                fb_nom_q[31:0] <= wdata_i;
            end
            if (wr_fbh) begin
                fb_nom_q[FB_W-1:32] <= wdata_i[FB_W-33:0];
            end
            if (wr_frl) begin
                fr_nom_q[31:0] <= wdata_i;
            end
            if (wr_frh) begin
                fr_nom_q[FR_W-1:32] <= wdata_i[FR_W-33:0];
            end
            if (wr_stp) begin
                step_q <= wdata_i[STEP_W-1:0];
            end
            if (wr_rmp) begin
                ramp_q <= wdata_i[CNT_W-1:0];
            end
            if (wr_lc4) begin
                loop_ctrl4_q <= wdata_i[LC4_W-1:0];
            end
        end
    end

    wire down_mode = spread_ctrl_q[`SSSP_SC_DOWN];
    wire [1:0] prescale = spread_ctrl_q[`SSSP_SC_PRE_MSB:`SSSP_SC_PRE_LSB];

    // spread enable from bit or selected gpio; 0 in pin select means bit only
    wire spread_req = src_pick(spread_ctrl_q[`SSSP_SC_PIN_MSB:`SSSP_SC_PIN_LSB],
                               spread_ctrl_q[`SSSP_SC_EN], gpio_i); // [RQ1]
    wire run = spread_req && loop_lock_i; // [RQ9]

    // prescale divider gives one tick per 2^prescale input cycles, fractional path only
    reg [3:0] pre_cnt_q;
    wire [3:0] pre_max = divsel_q ? ((4'h1 << prescale) - 4'h1) : 4'h0; // [RQ13]
    wire tick = (pre_cnt_q == pre_max);

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_cnt_q <= 4'h0;
        end else if (!run || tick) begin
            pre_cnt_q <= 4'h0;
        end else begin
            pre_cnt_q <= pre_cnt_q + 4'h1;
        end
    end

    // ramp counter and quarter index; a ramp is ramp_q plus two ticks
    // ramp order as one-hot states; center walks a, b, c, d, down spread only a, b
    localparam [3:0] RAMP_A = 4'b0001;
    localparam [3:0] RAMP_B = 4'b0010;
    localparam [3:0] RAMP_C = 4'b0100;
    localparam [3:0] RAMP_D = 4'b1000;
    reg [CNT_W:0] cnt_q;
    reg [3:0] ramp_st_q;
    reg [3:0] ramp_st_d;
    wire ramp_end = (cnt_q == {(CNT_W+1){1'b0}});
    wire [CNT_W:0] reload = {1'b0, ramp_q} + {{CNT_W{1'b0}}, 1'b1};

    // center spread: up, down, down, up so the wave sits around nominal
    // down spread: one half-period ramp down then up, never above nominal
    wire dn_center = (ramp_st_q == RAMP_B) || (ramp_st_q == RAMP_C);
    wire dn_down = (ramp_st_q == RAMP_A) || (ramp_st_q == RAMP_C);
    wire go_down = down_mode ? dn_down : dn_center; // [RQ3] [RQ4]

    // a mode change mid-run folds c and d back onto the two down-spread ramps
    always @* begin
        ramp_st_d = RAMP_A;
        case (ramp_st_q)
            RAMP_A: begin
                ramp_st_d = RAMP_B;
            end
            RAMP_B: begin
                ramp_st_d = down_mode ? RAMP_A : RAMP_C;
            end
            RAMP_C: begin
                ramp_st_d = down_mode ? RAMP_B : RAMP_D;
            end
            RAMP_D: begin
                ramp_st_d = RAMP_A;
            end
            default: begin
                ramp_st_d = RAMP_A;
            end
        endcase
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= {(CNT_W+1){1'b0}};
            ramp_st_q <= RAMP_A;
        end else if (!run) begin
            cnt_q <= reload; // [RQ25]
            ramp_st_q <= RAMP_A;
        end else if (tick) begin
            if (ramp_end) begin
                cnt_q <= reload; // [RQ24]
                ramp_st_q <= ramp_st_d; // [RQ24]
            end else begin
                cnt_q <= cnt_q - {{CNT_W{1'b0}}, 1'b1};
            end
        end
    end

    // frequency falls as fb value falls but as the fractional value rises
    wire [FB_W-1:0] fb_step = {{(FB_W-STEP_W){1'b0}}, step_q};
    wire [FR_W-1:0] fr_step = {{(FR_W-STEP_W){1'b0}}, step_q};

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fb_div_o <= `SSSP_RST_FB;
            frac_div_o <= `SSSP_RST_FR;
        end else begin
            if (!run || divsel_q) begin
                fb_div_o <= fb_nom_q; // [RQ25]
            end else if (tick) begin
                fb_div_o <= go_down ? fb_div_o - fb_step : fb_div_o + fb_step; // [RQ2] [RQ5] [RQ6]
            end
            if (!run || !divsel_q) begin
                frac_div_o <= fr_nom_q; // [RQ25]
            end else if (tick) begin
                frac_div_o <= go_down ? frac_div_o + fr_step : frac_div_o - fr_step; // [RQ10] [RQ11] [RQ12]
            end
        end
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            spread_active_o <= 1'b0;
        end else begin
            spread_active_o <= run;
        end
    end

    // phase step triggers, both edges count
    wire dec_lvl = src_pick(loop_ctrl4_q[`SSSP_LC4_DSRC_MSB:`SSSP_LC4_DSRC_LSB],
                            loop_ctrl4_q[`SSSP_LC4_DEC], gpio_i); // [RQ19]
    wire inc_lvl = src_pick(loop_ctrl4_q[`SSSP_LC4_ISRC_MSB:`SSSP_LC4_ISRC_LSB],
                            loop_ctrl4_q[`SSSP_LC4_INC], gpio_i); // [RQ20]
    reg dec_prev_q;
    reg inc_prev_q;
    reg prev_valid_q;

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dec_prev_q <= 1'b0;
            inc_prev_q <= 1'b0;
            prev_valid_q <= 1'b0;
            phase_inc_int_o <= 1'b0;
            phase_dec_int_o <= 1'b0;
            phase_inc_frac_o <= 1'b0;
            phase_dec_frac_o <= 1'b0;
            phase_step_eighth_o <= 1'b0;
        end else begin
            dec_prev_q <= dec_lvl;
            inc_prev_q <= inc_lvl;
            // first cycle after reset only primes history, no false edge
            prev_valid_q <= 1'b1;
            phase_dec_int_o <= prev_valid_q && (dec_lvl ^ dec_prev_q); // [RQ21] [RQ22]
            phase_dec_frac_o <= prev_valid_q && (dec_lvl ^ dec_prev_q); // [RQ22]
            phase_inc_int_o <= prev_valid_q && (inc_lvl ^ inc_prev_q); // [RQ21] [RQ22]
            phase_inc_frac_o <= prev_valid_q && (inc_lvl ^ inc_prev_q); // [RQ22]
            // step size follows the live feedback value, modulation included
            phase_step_eighth_o <= |fb_div_o[`SSSP_FB_HALF_MSB:`SSSP_FB_HALF_LSB]; // [RQ17] [RQ18]
        end
    end

    // register read, data one cycle after the strobe, unmapped reads zero
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0000_0000;
        // slices over the zeroed word, so a full-width step needs no empty pad
        case (addr_i)
            `SSSP_OFS_SPREAD_CTRL: begin
                rd_mux[SC_W-1:0] = spread_ctrl_q;
            end
            `SSSP_OFS_LOOP_CTRL1: begin
                rd_mux[`SSSP_LC1_DIVSEL] = divsel_q;
            end
            `SSSP_OFS_FB_LO: begin
                rd_mux = fb_nom_q[31:0];
            end
            `SSSP_OFS_FB_HI: begin
                rd_mux[FB_W-33:0] = fb_nom_q[FB_W-1:32];
            end
            `SSSP_OFS_FR_LO: begin
                rd_mux = fr_nom_q[31:0];
            end
            `SSSP_OFS_FR_HI: begin
                rd_mux[FR_W-33:0] = fr_nom_q[FR_W-1:32];
            end
            `SSSP_OFS_STEP: begin
                rd_mux[STEP_W-1:0] = step_q;
            end
            `SSSP_OFS_RAMP: begin
                rd_mux[CNT_W-1:0] = ramp_q;
            end
            `SSSP_OFS_LOOP_CTRL4: begin
                rd_mux[LC4_W-1:0] = loop_ctrl4_q;
            end
            `SSSP_OFS_STATUS: begin
                rd_mux[`SSSP_ST_LOCK] = loop_lock_i;
                rd_mux[`SSSP_ST_ACTIVE] = spread_active_o;
                rd_mux[`SSSP_ST_DOWN] = go_down;
                rd_mux[`SSSP_ST_EIGHTH] = phase_step_eighth_o;
            end
            `SSSP_OFS_CUR_FB_LO: begin
                rd_mux = fb_div_o[31:0];
            end
            `SSSP_OFS_CUR_FR_LO: begin
                rd_mux = frac_div_o[31:0];
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_o <= rd_mux;
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

endmodule // sssp_top

// *** dv/sssp_top_asserts.sv ***
// port-level assertion checker for the spread and phase step block
`timescale 1ns/1ps
module sssp_top_asserts #(
    parameter FB_W = 42,
    parameter FR_W = 40,
    parameter GPIO_N = 4
) (
    input wire ref_clk_i,
    input wire rst_i,
    input wire wr_i,
    input wire loop_lock_i,
    input wire [GPIO_N-1:0] gpio_i,
    input wire [FB_W-1:0] fb_div_o,
    input wire [FR_W-1:0] frac_div_o,
    input wire spread_active_o,
    input wire phase_inc_int_o,
    input wire phase_dec_int_o,
    input wire phase_inc_frac_o,
    input wire phase_dec_frac_o,
    input wire phase_step_eighth_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_inc_pair_same: assert property (phase_inc_int_o == phase_inc_frac_o)
        else $error("inc pulses differ");
    a_dec_pair_same: assert property (phase_dec_int_o == phase_dec_frac_o)
        else $error("dec pulses differ");
    a_lock_gates_run: assert property (spread_active_o |-> $past(loop_lock_i))
        else $error("modulation without lock");
    a_eighth_flag_tracks: assert property (phase_step_eighth_o == ($past(fb_div_o[31:0]) != 32'h0))
        else $error("step size flag wrong");
    // a start of run may move the divider on the same edge that raises active
    a_idle_div_hold: assert property ((!spread_active_o && !$past(spread_active_o) && !wr_i && !$past(wr_i)
        && !$past(wr_i, 2)) |=> (spread_active_o || ($stable(fb_div_o) && $stable(frac_div_o))))
        else $error("divider moved while idle");
    a_one_div_moves: assert property ((spread_active_o && $past(spread_active_o) && !$past(wr_i))
        |-> ($stable(fb_div_o) || $stable(frac_div_o)))
        else $error("both dividers moved");
    a_inc_has_cause: assert property (phase_inc_int_o |-> ($past(gpio_i) != $past(gpio_i, 2)
        || $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3)))
        else $error("inc pulse without edge");
    a_dec_has_cause: assert property (phase_dec_int_o |-> ($past(gpio_i) != $past(gpio_i, 2)
        || $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3)))
        else $error("dec pulse without edge");
endmodule // sssp_top_asserts

bind sssp_top sssp_top_asserts #(.FB_W(FB_W), .FR_W(FR_W), .GPIO_N(GPIO_N)) i_sssp_top_asserts (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wr_i(wr_i), .loop_lock_i(loop_lock_i), .gpio_i(gpio_i),
    .fb_div_o(fb_div_o), .frac_div_o(frac_div_o), .spread_active_o(spread_active_o),
    .phase_inc_int_o(phase_inc_int_o), .phase_dec_int_o(phase_dec_int_o), .phase_inc_frac_o(phase_inc_frac_o),
    .phase_dec_frac_o(phase_dec_frac_o), .phase_step_eighth_o(phase_step_eighth_o));

// *** dv/sssp_top_tb.sv ***
// self-checking testbench for the spread and phase step block
`timescale 1ns/1ps
module sssp_top_tb;
    reg ref_clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg [7:0] addr_i = 8'h00;
    reg [31:0] wdata_i = 32'h0000_0000;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg loop_lock_i = 1'b0;
    reg [3:0] gpio_i = 4'h0;
    wire [31:0] rdata_o;
    wire [41:0] fb_div_o;
    wire [39:0] frac_div_o;
    wire spread_active_o, phase_inc_int_o, phase_dec_int_o, phase_inc_frac_o, phase_dec_frac_o, phase_step_eighth_o;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    int inc_cnt = 0;
    int dec_cnt = 0;
    int incf_cnt = 0;
    int decf_cnt = 0;
    sssp_top i_sssp_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .loop_lock_i(loop_lock_i), .gpio_i(gpio_i), .fb_div_o(fb_div_o),
        .frac_div_o(frac_div_o), .spread_active_o(spread_active_o), .phase_inc_int_o(phase_inc_int_o),
        .phase_dec_int_o(phase_dec_int_o), .phase_inc_frac_o(phase_inc_frac_o),
        .phase_dec_frac_o(phase_dec_frac_o), .phase_step_eighth_o(phase_step_eighth_o));
    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        inc_cnt <= inc_cnt + (phase_inc_int_o === 1'b1);
        dec_cnt <= dec_cnt + (phase_dec_int_o === 1'b1);
        incf_cnt <= incf_cnt + (phase_inc_frac_o === 1'b1);
        decf_cnt <= decf_cnt + (phase_dec_frac_o === 1'b1);
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [41:0] seen, input logic [41:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        @(negedge ref_clk_i);
        d = rdata_o;
    endtask
    function automatic logic [41:0] cur(input int sel);
        return sel ? {2'b00, frac_div_o} : fb_div_o;
    endfunction
    // triangle offset in steps at tick k; center runs up, down, down, up
    function automatic int tri_pos(input int k, input int len, input int down);
        int p, r, i;
        p = (k - 1) % (down ? 2 * len : 4 * len);
        r = p / len + (down ? 2 : 0);
        i = p % len + 1;
        case (r)
            0: return i;
            1: return len - i;
            2: return -i;
            default: return i - len;
        endcase
    endfunction
    task automatic spread(input int divsel, input int down);
        logic [41:0] nom;
        int stp, ramp, pre, pin, len, j, m, n;
        nom = {10'h020, $urandom()};
        stp = $urandom_range(255, 1);
        ramp = $urandom_range(3, 0);
        pre = divsel ? $urandom_range(2, 0) : 0;
        pin = $urandom_range(4, 0);
        len = ramp + 2;
        n = (down ? 4 : 8) * len * (1 << pre);
        @(posedge ref_clk_i);
        loop_lock_i <= 1'b0;
        wr(8'h20, 32'h0000_00b4);
        wr(8'h08, nom[31:0]); // no remainder or denominator kept here
        wr(8'h0C, {22'h0, nom[41:32]});
        wr(8'h10, nom[31:0]); // fractional path, no mode field here
        wr(8'h14, {24'h0, nom[39:32]});
        wr(8'h18, stp); // small unscaled step, no frequency stepping
        wr(8'h1C, ramp);
        wr(8'h04, divsel);
        wr(8'h00, {25'h0, pre[1:0], pin[2:0], down[0], pin == 0});
        if (pin != 0) gpio_i <= 4'h1 << (pin - 1);
        repeat (6) @(negedge ref_clk_i);
        chk("held while unlocked", cur(divsel), nom);
        @(posedge ref_clk_i);
        loop_lock_i <= 1'b1;
        for (j = 0; j < 40; j++) begin
            @(negedge ref_clk_i);
            if (cur(divsel) !== nom) break;
        end
        chk("running", spread_active_o, 1'b1);
        for (j = 0; j < n; j++) begin
            m = tri_pos((j >> pre) + 1, len, down);
            chk("divider", cur(divsel), nom + 42'(divsel ? -m * stp : m * stp));
            chk("other divider", cur(1 - divsel), nom);
            @(negedge ref_clk_i);
        end
        if ($urandom_range(1, 0)) begin
            @(posedge ref_clk_i);
            loop_lock_i <= 1'b0;
        end else begin
            wr(8'h00, 32'h0000_0000);
            gpio_i <= 4'h0;
        end
        repeat (3) @(negedge ref_clk_i);
        chk("back to nominal", cur(divsel), nom);
        chk("active", spread_active_o, 1'b0);
    endtask
    task automatic phase(input int inc, input int src);
        logic [31:0] ctl;
        int ci, cd, fi, fd, k;
        ctl = inc ? {24'h0, src[2:0], 5'h14} : {24'h0, 3'h5, src[2:0], 2'b00};
        wr(8'h20, ctl);
        repeat (3) @(negedge ref_clk_i);
        ci = inc_cnt;
        cd = dec_cnt;
        fi = incf_cnt;
        fd = decf_cnt;
        for (k = 0; k < 2; k++) begin
            if (src == 0) begin
                ctl[inc] = ~ctl[inc];
                wr(8'h20, ctl);
            end else begin
                @(posedge ref_clk_i);
                gpio_i <= gpio_i ^ (4'h1 << (src - 1));
            end
            repeat (4) @(negedge ref_clk_i);
        end
        chk("inc pulses", 42'(inc_cnt - ci), inc ? 42'h2 : 42'h0);
        chk("dec pulses", 42'(dec_cnt - cd), inc ? 42'h0 : 42'h2);
        chk("inc frac pulses", 42'(incf_cnt - fi), inc ? 42'h2 : 42'h0);
        chk("dec frac pulses", 42'(decf_cnt - fd), inc ? 42'h0 : 42'h2);
    endtask
    initial begin
        logic [31:0] d;
        int i;
        void'($urandom(32'h8f5e));
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        wr(8'h08, 32'h0000_0000);
        wr(8'h0C, 32'h0000_0001);
        repeat (3) @(negedge ref_clk_i);
        rd(8'h24, d);
        chk("half multiple step", d[3], 1'b0);
        chk("one cycle pin", phase_step_eighth_o, 1'b0);
        chk("lock flag", d[0], 1'b0);
        wr(8'h08, 32'h8000_0000);
        repeat (3) @(negedge ref_clk_i);
        rd(8'h24, d);
        chk("eighth step", d[3], 1'b1);
        chk("eighth pin", phase_step_eighth_o, 1'b1);
        rd(8'h28, d);
        chk("current fb", d, 32'h8000_0000);
        rd(8'h40, d);
        chk("unmapped read", d, 32'h0000_0000);
        for (i = 0; i < 8; i++) spread(i % 2, (i / 2) % 2);
        for (i = 0; i < 10; i++) phase(i % 2, i / 2);
        end_of_test();
    end
endmodule // sssp_top_tb
